// ==== shared/sram_ctl_pkg.sv ====
// shared constants and types for the standby ram controller
package sram_ctl_pkg;
    // array geometry
    localparam int ARRAY_BYTES = 4096;
    localparam int ARRAY_WORDS = ARRAY_BYTES / 2;
    localparam int OFFS_W      = 12;
    localparam int WIDX_W      = 11;
    // register block base, bit 23 comes from module_map_select
    localparam logic [22:0] REG_BLOCK_ADDR = 23'h7ffb40;
    localparam logic [1:0]  REG_CFG_IDX    = 2'h0;
    localparam logic [1:0]  REG_BAH_IDX    = 2'h2;
    localparam logic [1:0]  REG_BAL_IDX    = 2'h3;
    // config and base register fields
    localparam int CFG_STOP_BIT  = 15;
    localparam int CFG_LOCK_BIT  = 11;
    localparam int CFG_SPACE_LSB = 8;
    localparam int BAL_LSB       = 12;
    // reset values
    localparam logic        STOP_RST  = 1'b1;
    localparam logic        LOCK_RST  = 1'b0;
    localparam logic [1:0]  SPACE_RST = 2'h0;
    localparam logic [11:0] BASE_RST  = 12'h000;
    // function codes and the long word address step
    localparam logic [1:0] FC_DATA     = 2'h1;
    localparam logic [1:0] FC_PROG     = 2'h2;
    localparam logic [2:0] FC_SUP_DATA = 3'h5;
    localparam logic [23:0] WORD_STEP  = 24'h000002;

    typedef enum logic [1:0] {
        SZ_LONG = 2'b00,
        SZ_BYTE = 2'b01,
        SZ_WORD = 2'b10
    } size_e;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_EXEC1  = 2'b01,
        ST_DONE1  = 2'b10,
        ST_EXEC2  = 2'b11
    } state_e;

    typedef struct packed {
        logic [23:0] addr;
        logic [2:0]  fc;
        size_e       size;
        logic        write;
        logic [31:0] wdata;
    } bus_req_s;
endpackage : sram_ctl_pkg

// ==== verilog/standby_ram_control.sv ====
// standby ram array, its control registers and bus termination
// Functional notes
// - array window is 4 Kbyte aligned; only address bits above offset compared.
// - array reads and writes at byte, word and long size.
// - registers answer only supervisor data space accesses.
// - eight byte register block; unimplemented reads zero, writes ignored.
// - register block bit 23 follows the module mapping bit.
// - base registers writable only when stop is one and lock zero.
// - lock bit set once by a write, then frozen until reset.
// - space field picks program/data and privilege the array answers.
// - supervisor-only array ignores user accesses without terminating them.
// - byte or word takes two clocks; long word two bus cycles.
// - stop keeps contents and refuses all array accesses.
// - stop bit written only from supervisor mode.
// - running on standby supply blocks every array access.
// - reset sets stop, opens program and data space to all modes, clears bases and lock.
// - synchronous reset lets a byte or word access finish.
// - sync reset in first long word ends after it; in second, completes.
`timescale 1ns/10ps
`default_nettype none
module standby_ram_control
    import sram_ctl_pkg::*;
(
    // clock and resets
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        sync_reset,
    // system straps and power status
    input  wire logic        module_map_select,
    input  wire logic        standby_supply,
    // intermodule bus request
    input  wire logic        bus_req,
    input  wire bus_req_s    req,
    // intermodule bus answer
    output logic             ack,
    output logic [31:0]      rdata,
    // status
    output logic             low_power_stop,
    output logic             base_locked
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    state_e      state;
    state_e      next_state;
    bus_req_s    cur;
    bus_req_s    next_cur;
    logic        is_reg;
    logic        next_is_reg;
    logic        trunc;
    logic        next_trunc;
    logic        next_ack;
    logic [31:0] next_rdata;
    logic        stop;
    logic        next_stop;
    logic        lock;
    logic        next_lock;
    logic [1:0]  space;
    logic [1:0]  next_space;
    logic [11:0] base;
    logic [11:0] next_base;
    logic [15:0] mem [ARRAY_WORDS];

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    logic              win_hit;
    logic              space_ok;
    logic              arr_claim;
    logic              reg_claim;
    logic              take;
    logic              in_prog;
    logic              in_data;
    logic              in_sup;

    assign in_prog   = (req.fc[1:0] == FC_PROG);
    assign in_data   = (req.fc[1:0] == FC_DATA);
    assign in_sup    = req.fc[2];
    // upper bits only, so the base is always array aligned
    assign win_hit   = (req.addr[23:OFFS_W] == base);
    // bit 0 drops data space, bit 1 drops user mode
    assign space_ok  = (in_prog || (in_data && !space[0]))
                     && (in_sup || !space[1]);
    assign arr_claim = win_hit && space_ok && !stop
                     && !standby_supply;
    // an overlapping window shadows the registers
    assign reg_claim = !win_hit && (req.fc == FC_SUP_DATA)
                     && (req.addr[23:3] == {module_map_select,
                                            REG_BLOCK_ADDR[22:3]});
    // ack high means the requester is still dropping its strobe
    assign take      = (state == ST_IDLE) && bus_req && !ack
                     && !sync_reset && (arr_claim || reg_claim);

    // ------------------------------------------------------------
    // word operation of the current bus cycle
    // ------------------------------------------------------------
    logic              op_en;
    logic              first;
    logic              be_hi;
    logic              be_lo;
    logic [15:0]       wword;
    logic [15:0]       rword;
    logic [15:0]       reg_rd;
    logic [WIDX_W-1:0] widx;

    assign op_en = (state == ST_EXEC1) || (state == ST_EXEC2);
    assign first = (state == ST_EXEC1) && (cur.size == SZ_LONG);
    assign widx  = cur.addr[OFFS_W-1:1];
    // even byte on the upper lane, odd byte on the lower
    assign be_hi = (cur.size != SZ_BYTE) || !cur.addr[0];
    assign be_lo = (cur.size != SZ_BYTE) || cur.addr[0];
    assign wword = first ? cur.wdata[31:16] : cur.wdata[15:0];
    assign rword = is_reg ? reg_rd : mem[widx];

    // register read mux, holes and the test register read zero
    always_comb begin
        case (cur.addr[2:1])
            REG_CFG_IDX: reg_rd = {stop, 3'h0, lock, 1'b0, space, 8'h00};
            REG_BAH_IDX: reg_rd = {8'h00, base[11:4]};
            REG_BAL_IDX: reg_rd = {base[3:0], 12'h000};
            default:     reg_rd = 16'h0000;
        endcase
    end

    // array writes, per byte lane; no reset so contents survive
    always_ff @(posedge ref_clk) begin
        if (op_en && !is_reg && cur.write && be_hi) begin
            mem[widx][15:8] <= wword[15:8];
        end
        if (op_en && !is_reg && cur.write && be_lo) begin
            mem[widx][7:0] <= wword[7:0];
        end
    end

    // ------------------------------------------------------------
    // sequencer and registers: next values
    // ------------------------------------------------------------
    always_comb begin
        next_state  = state;
        next_cur    = cur;
        next_is_reg = is_reg;
        next_trunc  = trunc;
        next_ack    = 1'b0;
        next_rdata  = rdata;
        next_stop   = stop;
        next_lock   = lock;
        next_space  = space;
        next_base   = base;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    next_cur    = req;
                    next_is_reg = reg_claim;
                    next_trunc  = 1'b0;
                    next_rdata  = 32'h00000000;
                    next_state  = ST_EXEC1;
                end
            end
            ST_EXEC1: begin
                if (cur.size == SZ_LONG) begin
                    // remember a reset seen in the first word
                    next_trunc    = sync_reset;
                    next_cur.addr = cur.addr + WORD_STEP;
                    next_state    = ST_DONE1;
                end else begin
                    // byte and word finish even under reset
                    next_ack   = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            ST_DONE1: begin
                if (trunc || sync_reset) begin
                    next_ack   = 1'b1;
                    next_state = ST_IDLE;
                end else begin
                    next_state = ST_EXEC2;
                end
            end
            ST_EXEC2: begin
                // second word always completes once started
                next_ack   = 1'b1;
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase

        // read data placement: long word high half first
        if (op_en && !cur.write) begin
            if (first) begin
                next_rdata[31:16] = rword;
            end else begin
                next_rdata[15:0] = rword;
            end
        end

        // register writes, dropped for unimplemented offsets
        if (op_en && is_reg && cur.write) begin
            if (cur.addr[2:1] == REG_CFG_IDX && be_hi) begin
                if (cur.fc[2]) begin
                    next_stop = wword[CFG_STOP_BIT];
                end
                if (wword[CFG_LOCK_BIT]) begin
                    next_lock = 1'b1;
                end
                next_space = wword[CFG_SPACE_LSB+1:CFG_SPACE_LSB];
            end
            if (stop && !lock) begin
                if (cur.addr[2:1] == REG_BAH_IDX && be_lo) begin
                    next_base[11:4] = wword[7:0];
                end
                if (cur.addr[2:1] == REG_BAL_IDX && be_hi) begin
                    next_base[3:0] = wword[15:BAL_LSB];
                end
            end
        end

        // synchronous reset hits the registers, not the access
        if (sync_reset) begin
            next_stop  = STOP_RST;
            next_lock  = LOCK_RST;
            next_space = SPACE_RST;
            next_base  = BASE_RST;
        end
    end

    // ------------------------------------------------------------
    // sequencer and registers: flops
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            // access in flight is abandoned, data not guaranteed
            state          <= ST_IDLE;
            cur            <= '0;
            is_reg         <= 1'b0;
            trunc          <= 1'b0;
            ack            <= 1'b0;
            rdata          <= 32'h00000000;
            stop           <= STOP_RST;
            lock           <= LOCK_RST;
            space          <= SPACE_RST;
            base           <= BASE_RST;
            low_power_stop <= STOP_RST;
            base_locked    <= LOCK_RST;
        end else begin
            state          <= next_state;
            cur            <= next_cur;
            is_reg         <= next_is_reg;
            trunc          <= next_trunc;
            ack            <= next_ack;
            rdata          <= next_rdata;
            stop           <= next_stop;
            lock           <= next_lock;
            space          <= next_space;
            base           <= next_base;
            low_power_stop <= next_stop;
            base_locked    <= next_lock;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    a_short_two_clk: assert property (take && req.size != SZ_LONG |-> ##2 ack)
        else $error("byte or word access not acked after two clocks");
    a_long_four_clk: assert property (
        take && req.size == SZ_LONG ##1 !sync_reset [*2] |-> !ack ##1 !ack ##1 ack)
        else $error("long access not acked after four clocks");
    a_long_trunc: assert property (
        take && req.size == SZ_LONG ##1 sync_reset |-> ##2 ack)
        else $error("long access not ended after first word on reset");
    a_short_sync: assert property (
        take && req.size != SZ_LONG ##1 sync_reset |-> ##1 ack)
        else $error("short access not finished under reset");
    a_user_ignored: assert property (
        state == ST_IDLE && bus_req && !req.fc[2] && space[1] |=> state == ST_IDLE)
        else $error("user access claimed in supervisor mode");
    a_stop_refuse: assert property (
        state == ST_IDLE && bus_req && (stop || standby_supply) && !reg_claim
        |=> state == ST_IDLE && !ack)
        else $error("array claimed while stopped or on standby");
    a_reg_space: assert property (
        state == ST_IDLE && bus_req && req.fc != FC_SUP_DATA && !arr_claim
        |=> state == ST_IDLE)
        else $error("register claimed outside supervisor data");
    a_base_guard: assert property (
        !(stop && !lock) && !sync_reset |=> $stable(base))
        else $error("base changed while protected");
    a_lock_sticky: assert property (lock && !sync_reset |=> lock)
        else $error("lock bit cleared without reset");
    a_sync_defaults: assert property (
        sync_reset |=> stop && !lock && base == BASE_RST && space == SPACE_RST)
        else $error("sync reset left wrong register values");

    c_long_access: cover property (take && req.size == SZ_LONG ##4 ack);
    c_reg_write: cover property (take && reg_claim && req.write);
    c_long_trunc: cover property (take && req.size == SZ_LONG ##1 sync_reset);
    c_lock_set: cover property (!lock ##1 lock);

endmodule : standby_ram_control
`default_nettype wire

// ==== tb/cpu_bus_model.sv ====
// processor-side bus master model for the standby ram controller
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_model
    import sram_ctl_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // command from the bench
    input  wire logic        go,
    input  wire bus_req_s    cmd,
    // bus towards the controller
    output logic             bus_req,
    output bus_req_s         req,
    input  wire logic        ack,
    input  wire logic [31:0] rdata,
    // result of the last transfer
    output logic             busy,
    output logic             got_ack,
    output logic [31:0]      rd_data,
    output logic [3:0]       lat
);
    // ----------------------------------------
    // one transfer at a time
    // ----------------------------------------
    initial begin
        bus_req = 1'b0;
        req     = '0;
        busy    = 1'b0;
        got_ack = 1'b0;
        rd_data = '0;
        lat     = '0;
    end

    // request held steady until ack; released lines are scrambled so stale values never look valid
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_req <= 1'b0;
            busy    <= 1'b0;
            req     <= bus_req_s'(~req);
        end else if (go && !busy) begin
            bus_req <= 1'b1;
            req     <= cmd;
            busy    <= 1'b1;
            got_ack <= 1'b0;
            lat     <= 4'h0;
        end else if (bus_req) begin
            lat <= lat + 4'h1;
            if (ack) begin
                bus_req <= 1'b0;  // dropped in the ack cycle
                got_ack <= 1'b1;
                rd_data <= rdata;
                busy    <= 1'b0;
                req     <= bus_req_s'(~req);
            end else if (lat == 4'ha) begin
                bus_req <= 1'b0;  // unclaimed: outside decode would answer, so give up
                busy    <= 1'b0;
                req     <= bus_req_s'(~req);
            end
        end
    end
endmodule : cpu_bus_model
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the standby ram controller
`timescale 1ns/10ps
`default_nettype none
module testbench
    import sram_ctl_pkg::*;
;
    localparam logic [2:0] SD = FC_SUP_DATA;
    logic        ref_clk, reset_n, sync_reset, module_map_select, standby_supply;
    logic        bus_req, ack, low_power_stop, base_locked, go, busy, got_ack, ok;
    logic [31:0] rdata, rd_data;
    logic [3:0]  lat;
    logic [2:0]  f;
    logic [2:0]  fcs [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
    logic [23:0] regs;
    bus_req_s    req, cmd;
    int          errors, compares;

    assign regs = {module_map_select, REG_BLOCK_ADDR};
    initial ref_clk = 1'b0;
    always #4 ref_clk = ~ref_clk;

    standby_ram_control u_standby_ram_control (.ref_clk(ref_clk), .reset_n(reset_n), .sync_reset(sync_reset),
        .module_map_select(module_map_select), .standby_supply(standby_supply), .bus_req(bus_req), .req(req),
        .ack(ack), .rdata(rdata), .low_power_stop(low_power_stop), .base_locked(base_locked));
    cpu_bus_model u_cpu_bus_model (.ref_clk(ref_clk), .reset_n(reset_n), .go(go), .cmd(cmd), .bus_req(bus_req),
        .req(req), .ack(ack), .rdata(rdata), .busy(busy), .got_ack(got_ack), .rd_data(rd_data), .lat(lat));

    // ----------------------------------------
    // compare and access tasks
    // ----------------------------------------
    task automatic check_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
        end
    endtask : check_bit

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
        end
    endtask : check_word

    // one transfer, bounded wait; ea says whether the controller must claim it
    task automatic acc(input logic [23:0] a, input logic [2:0] fc, input size_e s, input logic w,
                       input logic [31:0] d, input logic ea, input logic [31:0] ed);
        @(posedge ref_clk);
        cmd <= '{addr: a, fc: fc, size: s, write: w, wdata: d};
        go  <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        #1;
        for (int i = 0; i < 40 && busy; i++) begin
            @(posedge ref_clk);
            #1;
        end
        check_bit(got_ack, ea);
        if (ea && !w) check_word(rd_data, ed);
    endtask : acc

    task automatic reg_wr(input logic [2:0] off, input logic [15:0] v);
        acc(regs + {21'h0, off}, SD, SZ_WORD, 1'b1, {16'h0, v}, 1'b1, '0);
    endtask : reg_wr

    task automatic reg_rd(input logic [2:0] off, input logic [15:0] v);
        acc(regs + {21'h0, off}, SD, SZ_WORD, 1'b0, '0, 1'b1, {16'h0, v});
    endtask : reg_rd

    // window back at 0x123000, stop cleared; kept clear of the register block
    task automatic restore;
        reg_wr(3'h4, 16'h0012);
        reg_wr(3'h6, 16'h3000);
        reg_wr(3'h0, 16'h0000);
    endtask : restore

    // sync reset sampled k edges after the take edge
    task automatic sync_at(input int k);
        @(posedge bus_req);
        repeat (k) @(posedge ref_clk);
        sync_reset <= 1'b1;
        @(posedge ref_clk);
        sync_reset <= 1'b0;
    endtask : sync_at

    task automatic final_report;
        if (errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        reset_n = 1'b0;
        sync_reset = 1'b0;
        module_map_select = 1'b1;
        standby_supply = 1'b0;
        go = 1'b0;
        cmd = '0;
        errors = 0;
        compares = 0;
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        reg_rd(3'h0, 16'h8000);
        reg_rd(3'h2, 16'h0000);
        reg_wr(3'h2, 16'hffff);
        reg_rd(3'h2, 16'h0000);
        acc(regs, 3'h1, SZ_WORD, 1'b1, '0, 1'b0, '0);
        check_bit(low_power_stop, 1'b1);
        acc({1'b0, REG_BLOCK_ADDR}, SD, SZ_WORD, 1'b0, '0, 1'b0, '0);
        acc(24'h000000, SD, SZ_WORD, 1'b0, '0, 1'b0, '0);
        restore;
        reg_rd(3'h6, 16'h3000);
        check_bit(low_power_stop, 1'b0);
        reg_wr(3'h4, 16'h0055);
        reg_rd(3'h4, 16'h0012);
        // lat counts edges with the request up: the take edge plus the bus cycle
        acc(24'h123000, SD, SZ_WORD, 1'b1, 32'h0000beef, 1'b1, '0);
        check_word({28'h0, lat}, 32'h3);
        acc(24'h123001, SD, SZ_BYTE, 1'b1, 32'h0000005a, 1'b1, '0);
        check_word({28'h0, lat}, 32'h3);
        acc(24'h123000, SD, SZ_BYTE, 1'b1, 32'h00001100, 1'b1, '0);
        acc(24'h123001, SD, SZ_BYTE, 1'b0, '0, 1'b1, 32'h0000115a);
        acc(24'h123ffc, SD, SZ_LONG, 1'b1, 32'hcafef00d, 1'b1, '0);
        check_word({28'h0, lat}, 32'h5);
        acc(24'h123ffc, SD, SZ_LONG, 1'b0, '0, 1'b1, 32'hcafef00d);
        acc(24'h123ffe, SD, SZ_WORD, 1'b0, '0, 1'b1, 32'h0000f00d);
        acc(24'h124000, SD, SZ_WORD, 1'b0, '0, 1'b0, '0);
        acc(24'h122ffe, SD, SZ_WORD, 1'b0, '0, 1'b0, '0);
        acc(24'h023000, SD, SZ_WORD, 1'b0, '0, 1'b0, '0);
        @(posedge ref_clk);
        standby_supply <= 1'b1;
        acc(24'h123000, SD, SZ_WORD, 1'b0, '0, 1'b0, '0);
        @(posedge ref_clk);
        standby_supply <= 1'b0;
        // every space setting against user and supervisor program and data function codes
        for (int sp = 0; sp < 4; sp++) begin
            reg_wr(3'h0, {6'h0, sp[1:0], 8'h00});
            for (int k = 0; k < 4; k++) begin
                f = fcs[k];
                ok = (!sp[0] || f[1:0] == FC_PROG) && (!sp[1] || f[2]);
                acc(24'h123000, f, SZ_WORD, 1'b0, '0, ok, 32'h0000115a);
            end
        end
        reg_wr(3'h0, 16'h8800);
        reg_wr(3'h0, 16'h8000);
        check_bit(base_locked, 1'b1);
        reg_wr(3'h4, 16'h0077);
        reg_rd(3'h4, 16'h0012);
        reg_rd(3'h0, 16'h8800);
        reg_wr(3'h0, 16'h0800);
        fork
            sync_at(1);
            acc(24'h123002, SD, SZ_WORD, 1'b1, 32'h00001234, 1'b1, '0);
        join
        check_word({28'h0, lat}, 32'h3);
        check_bit(base_locked, 1'b0);
        check_bit(low_power_stop, 1'b1);
        reg_rd(3'h4, 16'h0000);
        restore;
        acc(24'h123002, SD, SZ_WORD, 1'b0, '0, 1'b1, 32'h00001234);
        acc(24'h123010, SD, SZ_LONG, 1'b1, 32'h11112222, 1'b1, '0);
        fork
            sync_at(1);
            acc(24'h123010, SD, SZ_LONG, 1'b1, 32'haaaabbbb, 1'b1, '0);
        join
        check_word({28'h0, lat}, 32'h4);
        restore;
        acc(24'h123010, SD, SZ_LONG, 1'b0, '0, 1'b1, 32'haaaa2222);
        fork
            sync_at(3);
            acc(24'h123010, SD, SZ_LONG, 1'b1, 32'hccccdddd, 1'b1, '0);
        join
        check_word({28'h0, lat}, 32'h5);
        restore;
        acc(24'h123010, SD, SZ_LONG, 1'b0, '0, 1'b1, 32'hccccdddd);
        // window moved over the register block hides it; only a reset brings it back
        reg_wr(3'h0, 16'h8000);
        reg_wr(3'h4, 16'h00ff);
        reg_wr(3'h6, 16'hf000);
        acc(regs, SD, SZ_WORD, 1'b0, '0, 1'b0, '0);
        @(posedge ref_clk);
        sync_reset <= 1'b1;
        @(posedge ref_clk);
        sync_reset <= 1'b0;
        reg_rd(3'h4, 16'h0000);
        restore;
        // async reset right after the take: no answer may follow
        fork
            begin
                @(posedge bus_req);
                @(posedge ref_clk);
                reset_n <= 1'b0;
                @(posedge ref_clk);
                reset_n <= 1'b1;
            end
            acc(24'h123010, SD, SZ_WORD, 1'b0, '0, 1'b0, '0);
        join
        check_bit(low_power_stop, 1'b1);
        final_report();
    end

    // watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        final_report();
    end
endmodule : testbench
`default_nettype wire
